// ===== core/mic_irq_ctrl.sv
// interrupt controller of an 8-bit core: flags, enables, vectoring, wake
// assumes the core sequencer runs on core_clk_in and obeys take/push pulses
//
// How it works
// - twelve sources, each flag plus enable
// - flags set regardless of any enable
// - global enable at control bit seven
// - enabled pending source vectors core on the third instruction boundary
// - reset clears the global enable
// - take clears global enable, pushes pc, loads 0004h
// - return instruction sets global enable again
// - pin events vector within three-four cycles
// - latency ignores instruction length
// - pin edge polarity from option bit six
// - valid pin edge sets external flag
// - external enable gates the pin request
// - pin wakes sleep only when enabled
// - timer ff to 00 sets overflow flag
// - timer overflow enable at bit five
// - upper port change sets change flag
// - port change enable moved to bit three
// - peripheral flags gated by group enable
// - only return pc saved by hardware
// - enabled source wakes regardless of global enable
// - after wake with global enable set, next instruction then vector; here vectoring waits for the third boundary after wake
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
module mic_irq_ctrl #(
	parameter int PA_W = 8,
	parameter int PB_W = 1
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [mic_pkg::ADDR_W-1:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [mic_pkg::DATA_W-1:0] pwdata_in,
	output logic [mic_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic ext_irq_pin_in,
	input wire logic [3:0] upper_port_pins_in,
	input wire logic [mic_pkg::REG_W-1:0] timer_zero_count_in,
	input wire logic [PA_W-1:0] periph_event_a_in,
	input wire logic [PB_W-1:0] periph_event_b_in,
	input wire logic return_from_irq_instr_in,
	input wire logic sleep_in,
	input wire logic [mic_pkg::PC_W-1:0] return_pc_in,
	output mic_pkg::mic_vec_t vec_out,
	output logic wake_out,
	output logic asleep_out
);
	// three core sources plus both peripheral words, twelve at most
	generate
		if (PA_W < 1 || PB_W < 1 || PA_W > mic_pkg::REG_W ||
			PB_W > mic_pkg::REG_W ||
			PA_W + PB_W + mic_pkg::CORE_SRC > mic_pkg::MAX_SRC) begin : g_chk
			$error("mic_irq_ctrl: peripheral widths out of range");
		end
	endgenerate

	mic_pkg::mic_ctl_t ctl, next_ctl;
	logic [mic_pkg::REG_W-1:0] option;
	logic [PA_W-1:0] pflag_a, pen_a;
	logic [PB_W-1:0] pflag_b, pen_b;
	logic [mic_pkg::REG_W-1:0] timer_prev;
	logic [mic_pkg::Q_W-1:0] q_phase;
	logic [mic_pkg::LAT_W-1:0] lat_cnt;
	logic in_service;

	// pin synchronisers; stage one feeds stage two only
	logic [4:0] pin_s1, pin_s2, pin_prev;
	logic ext_edge, port_change, timer_roll;
	logic periph_req, request, pending, boundary, take_now, wake_req;
	logic wr_any;

	// no reset here: the chain tracks the pins through reset, so a pin
	// that idles high shows no false edge or change at release
	always_ff @(posedge core_clk_in) begin
		pin_s1 <= {upper_port_pins_in, ext_irq_pin_in};
		pin_s2 <= pin_s1;
		pin_prev <= pin_s2;
	end

	always_comb begin
		if (option[mic_pkg::OPT_EDGE_POL_BIT]) begin
			ext_edge = pin_s2[0] & ~pin_prev[0];
		end else begin
			ext_edge = ~pin_s2[0] & pin_prev[0];
		end
	end

	// a change of any upper pin counts, in either direction
	assign port_change = |(pin_s2[4:1] ^ pin_prev[4:1]);
	assign timer_roll = (timer_prev == mic_pkg::TIMER_TOP) &&
		(timer_zero_count_in == mic_pkg::TIMER_ZERO);

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			timer_prev <= mic_pkg::TIMER_ZERO;
		end else begin
			timer_prev <= timer_zero_count_in;
		end
	end

	// request forming, independent of global enable so it can serve wake-up
	assign periph_req = ctl.peripheral_group_enable &
		(|(pflag_a & pen_a) | |(pflag_b & pen_b));
	assign request = (ctl.ext_edge_flag & ctl.ext_edge_enable) |
		(ctl.timer_overflow_flag & ctl.timer_overflow_enable) |
		(ctl.port_change_flag & ctl.port_change_enable) |
		periph_req;
	assign pending = ctl.global_irq_enable & request;
	assign wake_req = request;

	// instruction phase counter; vectoring only on instruction boundaries
	// so one- and two-cycle instructions see the same latency
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			q_phase <= '0;
		end else begin
			q_phase <= q_phase + 1'b1;
		end
	end
	assign boundary = q_phase == mic_pkg::Q_LAST;

	always_ff @(posedge core_clk_in) begin
		if (rst_in || !pending || asleep_out) begin
			lat_cnt <= '0;
		end else if (boundary && lat_cnt != mic_pkg::LAT_TAKE) begin
			lat_cnt <= lat_cnt + 1'b1;
		end
	end

	// halted core cannot vector; after wake it vectors on the third instruction boundary
	assign take_now = pending && !asleep_out && boundary &&
		lat_cnt == mic_pkg::LAT_TAKE;

	assign wr_any = psel_in & penable_in & pwrite_in & pready_out;

	always_comb begin
		next_ctl = ctl;
		if (wr_any && paddr_in == mic_pkg::OFS_CTL) begin
			next_ctl = mic_pkg::mic_ctl_t'(pwdata_in[mic_pkg::REG_W-1:0]);
		end
		if (return_from_irq_instr_in) begin
			next_ctl.global_irq_enable = 1'b1;
		end
		if (take_now) begin
			next_ctl.global_irq_enable = 1'b0;
		end
		// events after the write: a set beats a clear in the same cycle
		if (ext_edge) begin
			next_ctl.ext_edge_flag = 1'b1;
		end
		if (timer_roll) begin
			next_ctl.timer_overflow_flag = 1'b1;
		end
		if (port_change) begin
			next_ctl.port_change_flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctl <= mic_pkg::mic_ctl_t'(mic_pkg::CTL_RESET);
		end else begin
			ctl <= next_ctl;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			option <= mic_pkg::OPTION_RESET;
		end else if (wr_any && paddr_in == mic_pkg::OFS_OPTION) begin
			option <= pwdata_in[mic_pkg::REG_W-1:0];
		end
	end

	// peripheral flag and enable words; events win over a software clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pflag_a <= PA_W'(mic_pkg::PREG_RESET);
			pflag_b <= PB_W'(mic_pkg::PREG_RESET);
		end else begin
			if (wr_any && paddr_in == mic_pkg::OFS_PFLAG_A) begin
				pflag_a <= pwdata_in[PA_W-1:0] | periph_event_a_in;
			end else begin
				pflag_a <= pflag_a | periph_event_a_in;
			end
			if (wr_any && paddr_in == mic_pkg::OFS_PFLAG_B) begin
				pflag_b <= pwdata_in[PB_W-1:0] | periph_event_b_in;
			end else begin
				pflag_b <= pflag_b | periph_event_b_in;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pen_a <= PA_W'(mic_pkg::PREG_RESET);
			pen_b <= PB_W'(mic_pkg::PREG_RESET);
		end else begin
			if (wr_any && paddr_in == mic_pkg::OFS_PEN_A) begin
				pen_a <= pwdata_in[PA_W-1:0];
			end
			if (wr_any && paddr_in == mic_pkg::OFS_PEN_B) begin
				pen_b <= pwdata_in[PB_W-1:0];
			end
		end
	end

	// vectoring: only the return pc is handed to the stack
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			vec_out.take <= 1'b0;
			vec_out.push_addr <= '0;
			vec_out.load_pc <= mic_pkg::IRQ_VECTOR;
		end else begin
			vec_out.take <= take_now;
			vec_out.load_pc <= mic_pkg::IRQ_VECTOR;
			if (take_now) begin
				vec_out.push_addr <= return_pc_in;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			in_service <= 1'b0;
		end else if (take_now) begin
			in_service <= 1'b1;
		end else if (return_from_irq_instr_in) begin
			in_service <= 1'b0;
		end
	end

	// sleep: a pending enabled source at sleep entry wakes at once
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			asleep_out <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			wake_out <= asleep_out && wake_req;
			if (asleep_out && wake_req) begin
				asleep_out <= 1'b0;
			end else if (sleep_in) begin
				asleep_out <= 1'b1;
			end
		end
	end

	// apb: no wait states, read data captured in the setup cycle
	mic_pkg::mic_stat_t stat;
	logic [mic_pkg::DATA_W-1:0] rd_mux;
	logic rd_err;

	assign stat = '{zero: '0, in_service: in_service,
		asleep: asleep_out, pending: pending};

	always_comb begin
		rd_err = 1'b0;
		case (paddr_in)
			mic_pkg::OFS_CTL: rd_mux = mic_pkg::DATA_W'(ctl);
			mic_pkg::OFS_OPTION: rd_mux = mic_pkg::DATA_W'(option);
			mic_pkg::OFS_PFLAG_A: rd_mux = mic_pkg::DATA_W'(pflag_a);
			mic_pkg::OFS_PFLAG_B: rd_mux = mic_pkg::DATA_W'(pflag_b);
			mic_pkg::OFS_PEN_A: rd_mux = mic_pkg::DATA_W'(pen_a);
			mic_pkg::OFS_PEN_B: rd_mux = mic_pkg::DATA_W'(pen_b);
			mic_pkg::OFS_STATUS: rd_mux = mic_pkg::DATA_W'(stat);
			default: begin
				rd_mux = '0;
				rd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= '0;
		end else begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & rd_err;
			if (psel_in && !penable_in && !pwrite_in) begin
				prdata_out <= rd_mux;
			end
		end
	end

	a_enable_reset_clear: assert property (@(posedge core_clk_in)
		disable iff (rst_in) $fell(rst_in) |-> !ctl.global_irq_enable)
		else $error("global enable not clear after reset");

	a_take_clears_enable: assert property (@(posedge core_clk_in)
		disable iff (rst_in) vec_out.take |-> !ctl.global_irq_enable &&
		vec_out.load_pc == mic_pkg::IRQ_VECTOR &&
		vec_out.push_addr == $past(return_pc_in))
		else $error("take without enable clear, vector or push");

	a_take_has_cause: assert property (@(posedge core_clk_in)
		disable iff (rst_in) $rose(vec_out.take) |->
		$past(ctl.global_irq_enable) && $past(request) &&
		$past(boundary))
		else $error("take without enabled pending source");

	a_pending_vectors: assert property (@(posedge core_clk_in)
		disable iff (rst_in) pending && !asleep_out && !vec_out.take
		&& !return_from_irq_instr_in && !wr_any ##1 pending && !wr_any &&
		!asleep_out ##1 pending && !wr_any && !asleep_out |->
		##[0:12] vec_out.take || !pending || asleep_out || wr_any)
		else $error("pending request not vectored in time");

	a_return_sets_enable: assert property (@(posedge core_clk_in)
		disable iff (rst_in) return_from_irq_instr_in && !take_now
		|=> ctl.global_irq_enable)
		else $error("return did not set global enable");

	a_ext_edge_flag: assert property (@(posedge core_clk_in)
		disable iff (rst_in) (option[mic_pkg::OPT_EDGE_POL_BIT] ?
		$rose(pin_s2[0]) : $fell(pin_s2[0])) |=> ctl.ext_edge_flag)
		else $error("valid pin edge did not set flag");

	a_timer_flag_set: assert property (@(posedge core_clk_in)
		disable iff (rst_in) timer_prev == mic_pkg::TIMER_TOP &&
		timer_zero_count_in == mic_pkg::TIMER_ZERO
		|=> ctl.timer_overflow_flag)
		else $error("timer rollover did not set flag");

	a_port_flag_set: assert property (@(posedge core_clk_in)
		disable iff (rst_in) pin_s2[4:1] != pin_prev[4:1]
		|=> ctl.port_change_flag)
		else $error("port change did not set flag");

	a_flag_sticky: assert property (@(posedge core_clk_in)
		disable iff (rst_in) ctl.ext_edge_flag &&
		!(wr_any && paddr_in == mic_pkg::OFS_CTL) |=> ctl.ext_edge_flag)
		else $error("flag cleared without software write");

	a_wake_on_request: assert property (@(posedge core_clk_in)
		disable iff (rst_in) asleep_out && request
		|=> wake_out && !asleep_out)
		else $error("enabled source failed to wake core");

	// a halted core or a cleared global enable must never see a vector
	a_take_needs_enable: assert property (@(posedge core_clk_in)
		disable iff (rst_in) !ctl.global_irq_enable || asleep_out
		|=> !vec_out.take)
		else $error("take while disabled or asleep");

	a_take_one_pulse: assert property (@(posedge core_clk_in)
		disable iff (rst_in) vec_out.take |=> !vec_out.take)
		else $error("take held for more than one cycle");

	a_wake_leaves_sleep: assert property (@(posedge core_clk_in)
		disable iff (rst_in) wake_out |-> !asleep_out && $past(asleep_out))
		else $error("wake pulse without leaving sleep");

	a_periph_flag_set: assert property (@(posedge core_clk_in)
		disable iff (rst_in) (|periph_event_a_in) |=>
		(pflag_a & $past(periph_event_a_in)) == $past(periph_event_a_in))
		else $error("peripheral event did not set its flag");

	// the access phase is answered in its first cycle, never twice
	a_ready_one_cycle: assert property (@(posedge core_clk_in)
		disable iff (rst_in) pready_out |=> !pready_out)
		else $error("ready held for more than one cycle");
endmodule
`default_nettype wire

// ===== pkg/mic_pkg.sv
// constants, field layouts and carrier types of the interrupt controller
// assumes a 32-bit apb slave port and a single core clock domain
`default_nettype none
package mic_pkg;
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PC_W = 13;
	localparam int CORE_SRC = 3;
	localparam int MAX_SRC = 12;

	// byte addresses of the register words
	localparam logic [ADDR_W-1:0] OFS_CTL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_OPTION = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PFLAG_A = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PFLAG_B = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PEN_A = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PEN_B = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

	localparam logic [REG_W-1:0] CTL_RESET = 8'h00;
	localparam logic [REG_W-1:0] OPTION_RESET = 8'hFF;
	localparam logic [REG_W-1:0] PREG_RESET = 8'h00;
	localparam int OPT_EDGE_POL_BIT = 6;

	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	localparam logic [REG_W-1:0] TIMER_TOP = 8'hFF;
	localparam logic [REG_W-1:0] TIMER_ZERO = 8'h00;

	// four clock phases make one instruction cycle
	localparam int Q_W = 2;
	localparam logic [Q_W-1:0] Q_LAST = 2'h3;
	// instruction boundaries counted from pending request to vectoring
	localparam int LAT_BOUNDS = 3;
	localparam int LAT_W = 2;
	localparam logic [LAT_W-1:0] LAT_TAKE = LAT_W'(LAT_BOUNDS - 1);

	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_group_enable;
		logic timer_overflow_enable;
		logic ext_edge_enable;
		logic port_change_enable;
		logic timer_overflow_flag;
		logic ext_edge_flag;
		logic port_change_flag;
	} mic_ctl_t;

	typedef struct packed {
		logic [4:0] zero;
		logic in_service;
		logic asleep;
		logic pending;
	} mic_stat_t;

	// vectoring request towards the core sequencer
	typedef struct packed {
		logic take;
		logic [PC_W-1:0] push_addr;
		logic [PC_W-1:0] load_pc;
	} mic_vec_t;
endpackage
`default_nettype wire

// ===== test/mic_core_model.sv
// core sequencer model: program counter, hardware stack, vector load
// assumes the controller's registered take pulse and one core clock
`default_nettype none
module mic_core_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire mic_pkg::mic_vec_t vec_in,
	output logic [mic_pkg::PC_W-1:0] pc_out,
	output logic [3:0] depth_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [mic_pkg::PC_W-1:0] stack [8];

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pc_out <= 13'h0100;
			depth_out <= 4'h0;
		end else if (vec_in.take) begin
			// only the return address is kept; no other context
			stack[depth_out[2:0]] <= vec_in.push_addr;
			depth_out <= depth_out + 4'h1;
			pc_out <= vec_in.load_pc;
		end else begin
			pc_out <= pc_out + 13'h0001;
		end
	end
endmodule
`default_nettype wire

// ===== test/mic_irq_ctrl_tb.sv
// testbench of the interrupt controller: register table, then events
// assumes the core model on the far side and a 200 MHz core clock
`default_nettype none
module mic_irq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] a; logic w; logic [7:0] d;
		logic [7:0] x; logic e;} mic_row_t;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic pin = 0, rfi = 0, slp = 0, pready, pslverr, wake, asleep, er;
	logic [7:0] paddr = 8'h00, tmr = 8'h00, pea = 8'h00;
	logic [0:0] peb = 1'h0;
	logic [3:0] up = 4'h0, depth;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [12:0] rpc, seen_push, exp_push;
	mic_pkg::mic_vec_t vec;
	int error_cnt = 0, n_tests = 0, takes = 0, wakes = 0, cyc = 0;
	int take_cyc = 0, t0, w0;
	mic_row_t rows [18] = '{
		{8'h00, 1'b0, 8'h00, 8'h00, 1'b0}, {8'h04, 1'b0, 8'h00, 8'hFF, 1'b0},
		{8'h08, 1'b0, 8'h00, 8'h00, 1'b0}, {8'h0C, 1'b0, 8'h00, 8'h00, 1'b0},
		{8'h10, 1'b0, 8'h00, 8'h00, 1'b0}, {8'h14, 1'b0, 8'h00, 8'h00, 1'b0},
		{8'h1C, 1'b1, 8'hAA, 8'h00, 1'b1}, {8'h1C, 1'b0, 8'h00, 8'h00, 1'b1},
		{8'h10, 1'b1, 8'h3C, 8'h00, 1'b0}, {8'h10, 1'b0, 8'h00, 8'h3C, 1'b0},
		{8'h14, 1'b1, 8'hFF, 8'h00, 1'b0}, {8'h14, 1'b0, 8'h00, 8'h01, 1'b0},
		{8'h10, 1'b1, 8'h00, 8'h00, 1'b0}, {8'h14, 1'b1, 8'h00, 8'h00, 1'b0},
		{8'h00, 1'b1, 8'h78, 8'h00, 1'b0}, {8'h00, 1'b0, 8'h00, 8'h78, 1'b0},
		{8'h00, 1'b1, 8'h00, 8'h00, 1'b0}, {8'h18, 1'b0, 8'h00, 8'h00, 1'b0}};

	mic_irq_ctrl dut (.core_clk_in(clk), .rst_in(rst), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .ext_irq_pin_in(pin),
		.upper_port_pins_in(up), .timer_zero_count_in(tmr),
		.periph_event_a_in(pea), .periph_event_b_in(peb),
		.return_from_irq_instr_in(rfi), .sleep_in(slp),
		.return_pc_in(rpc), .vec_out(vec), .wake_out(wake),
		.asleep_out(asleep));
	mic_core_model core (.clk_in(clk), .rst_in(rst), .vec_in(vec),
		.pc_out(rpc), .depth_out(depth));

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (vec.take === 1'b1) begin
			takes++;
			take_cyc = cyc;
			seen_push = vec.push_addr;
			exp_push = rpc - 13'h0001;
		end
		if (wake === 1'b1) wakes++;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value t=%0t seen %h want %h", $time, s, x);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// hold the request until pready is sampled, then one idle edge
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) error_cnt++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d}, rd, er);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] x);
		apb(a, 1'b0, 32'h0, rd, er);
		chk(rd, {24'h0, x});
	endtask
	// bounded wait for the next vectoring pulse
	task automatic wait_take(input int k);
		int n;
		n = 0;
		while (takes <= k && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		chk(vec.take, 1'b0);
		chk(vec.load_pc, 13'h0004);
		rst <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			apb(rows[i].a, rows[i].w, {24'h0, rows[i].d}, rd, er);
			chk(er, rows[i].e);
			if (!rows[i].w) chk(rd, {24'h0, rows[i].x});
		end
		$display("register table done");
		tmr <= 8'hFF;
		tick(1);
		tmr <= 8'h00;
		tick(2);
		rc(8'h00, 8'h04);
		wr(8'h00, 8'h24);
		tick(20);
		chk(takes, 0);
		wr(8'h00, 8'hA4);
		t0 = cyc;
		wait_take(0);
		chk(takes, 1);
		chk(take_cyc - t0 inside {[7:13]}, 1);
		chk(seen_push, exp_push);
		rc(8'h00, 8'h24);
		rc(8'h18, 8'h04);
		wr(8'h00, 8'h20); // flag cleared before return
		rfi <= 1'b1;
		tick(1);
		rfi <= 1'b0;
		tick(2);
		rc(8'h00, 8'hA0);
		tick(20);
		chk(takes, 1);
		$display("timer and vectoring done");
		for (int p = 0; p < 2; p++) begin
			wr(8'h04, p ? 8'hFF : 8'hBF);
			pin <= p[0];
			tick(6);
			wr(8'h00, 8'h00);
			pin <= ~p[0];
			tick(6);
			rc(8'h00, 8'h00);
			pin <= p[0];
			tick(6);
			rc(8'h00, 8'h02);
		end
		wr(8'h00, 8'h82);
		tick(20);
		chk(takes, 1);
		wr(8'h00, 8'h92);
		wait_take(1);
		chk(takes, 2);
		wr(8'h00, 8'h00);
		up <= 4'h5;
		tick(6);
		rc(8'h00, 8'h01);
		$display("pin and port events done");
		wr(8'h10, 8'h01);
		wr(8'h00, 8'h80);
		pea <= 8'h01;
		tick(1);
		pea <= 8'h00;
		tick(20);
		rc(8'h08, 8'h01);
		chk(takes, 2);
		wr(8'h00, 8'hC0);
		wait_take(2);
		chk(takes, 3);
		wr(8'h08, 8'h00);
		wr(8'h00, 8'h00);
		$display("peripheral group done");
		pin <= 1'b0;
		tick(6);
		wr(8'h00, 8'h10);
		slp <= 1'b1;
		tick(1);
		slp <= 1'b0;
		tick(2);
		chk(asleep, 1'b1);
		w0 = wakes;
		pin <= 1'b1;
		tick(8);
		chk(wakes, w0 + 1);
		chk(asleep, 1'b0);
		chk(takes, 3);
		chk(depth, 3);
		$display("sleep wake done");
		wr(8'h04, 8'hBF);
		wr(8'h00, 8'h80);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		rc(8'h00, 8'h00);
		rc(8'h04, 8'hFF);
		chk(vec.take, 1'b0);
		$display("mid-run reset done");
		stop_test();
	end
endmodule
`default_nettype wire
